/* design/poc_top.sv */
// How it works
// - pulse output four's energy type field at [11:9] picks active 000, reactive 001, apparent 010, fundamental reactive 100, and 011/101/110/111 mean active.
// - pulse outputs three, two, one have energy type fields at [8:6], [5:3], [2:0] with the same coding.
// - pulse output four's phase include field at [11:9] adds phase C by bit 2, phase B by bit 1, phase A by bit 0.
// - phase include fields for outputs three, two, one sit at [8:6], [5:3], [2:0] with the same bit meaning.
// - line frequency bit 8 selects 50 Hz at zero and 60 Hz at one, and feeds the fundamental reactive calculation.
// - without a zero crossing the resampler uses the nominal period of the selected line frequency.
// - with bit 7 set, phase B current is taken as minus the sum of phase A and phase C currents.
// - wiring code 000 keeps the voltages, code 001 makes phase B voltage A minus C.
// - wiring code 010 makes phase B voltage minus A minus C, code 011 makes it minus A.
// - wiring code 100 makes A as A minus B, B as A minus C, C as C minus B.
// - a set disable bit holds its pulse pin high and blocks its status flag on an accumulated pulse.
`default_nettype none
module poc_top
    import poc_pkg::*;
#(
    parameter int SAMPLE_W = 24,
    parameter int PERIOD_W = 20
) (
    input wire logic clk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic [11:0] reg_addr, // register address
    input wire logic reg_wr, // write strobe
    input wire logic [15:0] reg_wdata, // write data
    input wire logic reg_rd, // read strobe
    output logic [15:0] reg_rdata, // read data, one cycle after strobe
    input wire logic [3:0] pulse_raw, // converter pulse levels, bit0 = output one
    input wire logic [3:0] pulse_event, // converter accumulated-pulse strobes
    output logic pulse_out_one, // pulse pin one
    output logic pulse_out_two, // pulse pin two
    output logic pulse_out_three, // pulse pin three
    output logic pulse_out_four, // pulse pin four
    output logic [3:0] pulse_flag_set, // status flag set strobes
    output logic [15:0] energy_type_oh, // one-hot type per output, 4 bits each
    output logic [11:0] phase_include, // phase include bits per output
    output logic line_freq_60, // line frequency select
    output logic [3:0] accum_mode, // accumulation mode bits
    input wire logic zx_present, // zero crossing is present
    input wire logic [PERIOD_W-1:0] meas_period, // measured line period
    output logic [PERIOD_W-1:0] resample_period, // period used by resampler
    input wire logic signed [SAMPLE_W-1:0] phase_a_current, // measured current A
    input wire logic signed [SAMPLE_W-1:0] phase_b_current, // measured current B
    input wire logic signed [SAMPLE_W-1:0] phase_c_current, // measured current C
    input wire logic signed [SAMPLE_W-1:0] phase_a_voltage, // measured voltage A
    input wire logic signed [SAMPLE_W-1:0] phase_b_voltage, // measured voltage B
    input wire logic signed [SAMPLE_W-1:0] phase_c_voltage, // measured voltage C
    output logic signed [SAMPLE_W:0] ib_used, // current B after derivation
    output logic signed [SAMPLE_W:0] va_used, // voltage A after derivation
    output logic signed [SAMPLE_W:0] vb_used, // voltage B after derivation
    output logic signed [SAMPLE_W:0] vc_used // voltage C after derivation
);

    // register images
    logic [15:0] pulse_output_config_r;
    logic [15:0] pulse_phase_composition_r;
    logic [15:0] accumulation_config_r;
    logic [15:0] rdata_nxt;

    // field views and decoded selects
    logic [15:0] energy_type_nxt;
    logic [3:0] pulse_disable;
    logic [2:0] wiring_config_select;
    logic derive_middle_current;
    logic [3:0] pulse_pin_r;
    logic [PERIOD_W-1:0] nominal_period;

    // samples widened by one bit before any sum
    logic signed [SAMPLE_W:0] ia_x;
    logic signed [SAMPLE_W:0] ib_x;
    logic signed [SAMPLE_W:0] ic_x;
    logic signed [SAMPLE_W:0] va_x;
    logic signed [SAMPLE_W:0] vb_x;
    logic signed [SAMPLE_W:0] vc_x;

    // derived values ahead of their output registers
    logic signed [SAMPLE_W:0] ib_nxt;
    logic signed [SAMPLE_W:0] va_nxt;
    logic signed [SAMPLE_W:0] vb_nxt;
    logic signed [SAMPLE_W:0] vc_nxt;

    ////////////////////////////////////////////////////////////////////////
    // register port

    // a write lands at the edge that samples its strobe, reserved bits masked off
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pulse_output_config_r <= POC_PULSE_CFG_RST;
        end else if (reg_wr && reg_addr == POC_ADDR_PULSE_CFG) begin
            pulse_output_config_r <= reg_wdata & POC_PULSE_CFG_MASK;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pulse_phase_composition_r <= POC_COMP_RST;
        end else if (reg_wr && reg_addr == POC_ADDR_COMP) begin
            pulse_phase_composition_r <= reg_wdata & POC_COMP_MASK;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            accumulation_config_r <= POC_ACC_RST;
        end else if (reg_wr && reg_addr == POC_ADDR_ACC) begin
            accumulation_config_r <= reg_wdata & POC_ACC_MASK;
        end
    end

    // unmapped addresses read as zero
    always_comb begin
        unique case (reg_addr)
            POC_ADDR_PULSE_CFG: rdata_nxt = pulse_output_config_r;
            POC_ADDR_COMP: rdata_nxt = pulse_phase_composition_r;
            POC_ADDR_ACC: rdata_nxt = accumulation_config_r;
            default: rdata_nxt = 16'h0000;
        endcase
    end

    // read data holds until the next read strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end
    end

    // field views of the configuration registers
    assign pulse_disable = pulse_output_config_r[POC_DIS_LSB +: 4];
    assign wiring_config_select = accumulation_config_r[POC_WIRE_LSB +: POC_SEL_W];
    assign derive_middle_current = accumulation_config_r[POC_ICON_BIT];

    ////////////////////////////////////////////////////////////////////////
    // energy type decode, one field per output

    // codes without a meaning of their own fall back to total active power
    for (genvar g = 0; g < 4; g++) begin : g_type
        always_comb begin
            unique case (pulse_output_config_r[g*POC_SEL_W +: POC_SEL_W])
                POC_TYPE_REACTIVE: energy_type_nxt[g*4 +: 4] = POC_OH_REACTIVE;
                POC_TYPE_APPARENT: energy_type_nxt[g*4 +: 4] = POC_OH_APPARENT;
                POC_TYPE_FUND_REACT: energy_type_nxt[g*4 +: 4] = POC_OH_FUND_REACT;
                default: energy_type_nxt[g*4 +: 4] = POC_OH_ACTIVE;
            endcase
        end
    end

    // all four outputs come up on total active power
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            energy_type_oh <= {4{POC_OH_ACTIVE}};
        end else begin
            energy_type_oh <= energy_type_nxt;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_include <= 12'h000;
        end else begin
            phase_include <= pulse_phase_composition_r[11:0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            line_freq_60 <= 1'h0;
        end else begin
            line_freq_60 <= accumulation_config_r[POC_FREQ_BIT];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            accum_mode <= 4'h0;
        end else begin
            accum_mode <= accumulation_config_r[POC_ACCM_LSB +: POC_ACCM_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pulse pins and status strobes

    // a disabled output parks high and keeps its status flag quiet
    for (genvar g = 0; g < 4; g++) begin : g_pin
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                pulse_pin_r[g] <= 1'h1;
            end else begin
                pulse_pin_r[g] <= pulse_raw[g] | pulse_disable[g];
            end
        end

        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                pulse_flag_set[g] <= 1'h0;
            end else begin
                pulse_flag_set[g] <= pulse_event[g] & ~pulse_disable[g];
            end
        end
    end

    assign pulse_out_one = pulse_pin_r[0];
    assign pulse_out_two = pulse_pin_r[1];
    assign pulse_out_three = pulse_pin_r[2];
    assign pulse_out_four = pulse_pin_r[3];

    ////////////////////////////////////////////////////////////////////////
    // resampler period

    // the nominal period stands in until a zero crossing gives the measured one
    always_comb begin
        nominal_period = PERIOD_W'(POC_PERIOD_50HZ);
        if (accumulation_config_r[POC_FREQ_BIT]) begin
            nominal_period = PERIOD_W'(POC_PERIOD_60HZ);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            resample_period <= PERIOD_W'(POC_PERIOD_50HZ);
        end else if (zx_present) begin
            resample_period <= meas_period;
        end else begin
            resample_period <= nominal_period;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // current and voltage derivation

    // currents
    assign ia_x = {phase_a_current[SAMPLE_W-1], phase_a_current};
    assign ib_x = {phase_b_current[SAMPLE_W-1], phase_b_current};
    assign ic_x = {phase_c_current[SAMPLE_W-1], phase_c_current};

    // voltages
    assign va_x = {phase_a_voltage[SAMPLE_W-1], phase_a_voltage};
    assign vb_x = {phase_b_voltage[SAMPLE_W-1], phase_b_voltage};
    assign vc_x = {phase_c_voltage[SAMPLE_W-1], phase_c_voltage};

    always_comb begin
        va_nxt = va_x;
        vb_nxt = vb_x;
        vc_nxt = vc_x;
        unique case (wiring_config_select)
            POC_WIRE_DELTA3_B: vb_nxt = va_x - vc_x;
            POC_WIRE_WYE4_NB: vb_nxt = -va_x - vc_x;
            POC_WIRE_DELTA4_NB: vb_nxt = -va_x;
            POC_WIRE_DELTA3_ALL: begin
                va_nxt = va_x - vb_x;
                vb_nxt = va_x - vc_x;
                vc_nxt = vc_x - vb_x;
            end
            // wye and unassigned codes pass the measurements through
            default: begin
                va_nxt = va_x;
            end
        endcase
    end

    // the middle current is measured or rebuilt from the two outer ones
    always_comb begin
        ib_nxt = ib_x;
        if (derive_middle_current) begin
            ib_nxt = -ia_x - ic_x;
        end
    end

    // one bit of headroom keeps the sums and differences from wrapping, save minus A minus C when both are at negative full scale
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ib_used <= '0;
        end else begin
            ib_used <= ib_nxt;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            va_used <= '0;
        end else begin
            va_used <= va_nxt;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            vb_used <= '0;
        end else begin
            vb_used <= vb_nxt;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            vc_used <= '0;
        end else begin
            vc_used <= vc_nxt;
        end
    end

endmodule
`default_nettype wire

/* shared/poc_pkg.sv */
`default_nettype none
package poc_pkg;
    localparam logic [11:0] POC_ADDR_PULSE_CFG = 12'h490;
    localparam logic [11:0] POC_ADDR_COMP = 12'h491;
    localparam logic [11:0] POC_ADDR_ACC = 12'h492;
    localparam logic [15:0] POC_PULSE_CFG_RST = 16'h0000;
    localparam logic [15:0] POC_COMP_RST = 16'h0000;
    localparam logic [15:0] POC_ACC_RST = 16'h0000;
    localparam logic [15:0] POC_PULSE_CFG_MASK = 16'hFFFF;
    localparam logic [15:0] POC_COMP_MASK = 16'h0FFF;
    localparam logic [15:0] POC_ACC_MASK = 16'h01FF;
    localparam int POC_SEL_W = 3;
    localparam int POC_DIS_LSB = 12;
    localparam int POC_FREQ_BIT = 8;
    localparam int POC_ICON_BIT = 7;
    localparam int POC_WIRE_LSB = 4;
    localparam int POC_ACCM_LSB = 0;
    localparam int POC_ACCM_W = 4;
    localparam logic [2:0] POC_TYPE_ACTIVE = 3'h0;
    localparam logic [2:0] POC_TYPE_REACTIVE = 3'h1;
    localparam logic [2:0] POC_TYPE_APPARENT = 3'h2;
    localparam logic [2:0] POC_TYPE_FUND_REACT = 3'h4;
    localparam logic [2:0] POC_WIRE_WYE4 = 3'h0;
    localparam logic [2:0] POC_WIRE_DELTA3_B = 3'h1;
    localparam logic [2:0] POC_WIRE_WYE4_NB = 3'h2;
    localparam logic [2:0] POC_WIRE_DELTA4_NB = 3'h3;
    localparam logic [2:0] POC_WIRE_DELTA3_ALL = 3'h4;
    // one-hot energy type selects: bit0 active, 1 reactive, 2 apparent, 3 fundamental reactive
    localparam logic [3:0] POC_OH_ACTIVE = 4'h1;
    localparam logic [3:0] POC_OH_REACTIVE = 4'h2;
    localparam logic [3:0] POC_OH_APPARENT = 4'h4;
    localparam logic [3:0] POC_OH_FUND_REACT = 4'h8;
    // nominal line period in resampler timebase ticks
    localparam logic [19:0] POC_PERIOD_50HZ = 20'h0A000;
    localparam logic [19:0] POC_PERIOD_60HZ = 20'h08555;
endpackage
`default_nettype wire

/* verif/poc_top_assertions.sv */
`default_nettype none
module poc_top_assertions
    import poc_pkg::*;
(
    input wire logic clk, // clock
    input wire logic nrst, // reset
    input wire logic [11:0] reg_addr, // addr
    input wire logic reg_wr, // write
    input wire logic [15:0] reg_wdata, // wdata
    input wire logic reg_rd, // read
    input wire logic [15:0] reg_rdata, // rdata
    input wire logic [3:0] pulse_raw, // raw
    input wire logic [3:0] pulse_event, // events
    input wire logic pulse_out_one, // pin
    input wire logic pulse_out_two, // pin
    input wire logic pulse_out_three, // pin
    input wire logic pulse_out_four, // pin
    input wire logic [3:0] pulse_flag_set, // flags
    input wire logic [15:0] energy_type_oh, // types
    input wire logic [11:0] phase_include, // phases
    input wire logic line_freq_60, // freq
    input wire logic zx_present, // zx
    input wire logic [19:0] meas_period, // period in
    input wire logic [19:0] resample_period // period out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    wire wc = reg_wr && reg_addr == POC_ADDR_COMP;
    wire wa = reg_wr && reg_addr == POC_ADDR_ACC;
    wire wp = reg_wr && reg_addr == POC_ADDR_PULSE_CFG;
    wire [3:0] pins = {pulse_out_four, pulse_out_three, pulse_out_two, pulse_out_one};
    ////////////////////////////////////////////////////////////////
    property p_rsvd; reg_rd && reg_addr == POC_ADDR_COMP |=> reg_rdata[15:12] == 4'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    property p_incl; wc |=> ##1 phase_include == $past(reg_wdata[11:0], 2); endproperty
    a_incl: assert property (p_incl) else $error("phase include wrong");
    property p_freq; wa |=> ##1 line_freq_60 == $past(reg_wdata[8], 2); endproperty
    a_freq: assert property (p_freq) else $error("line freq wrong");
    property p_type; wp && reg_wdata[11:9] == 3'h2 |=> ##1 energy_type_oh[15:12] == POC_OH_APPARENT; endproperty
    a_type: assert property (p_type) else $error("type four wrong");
    property p_pin; pulse_event == 4'hF && pulse_raw == 4'h0 |=> pins == ~pulse_flag_set; endproperty
    a_pin: assert property (p_pin) else $error("pin and flag disagree");
    property p_flag; (pulse_flag_set & ~$past(pulse_event)) == 4'h0; endproperty
    a_flag: assert property (p_flag) else $error("flag without event");
    property p_zx; zx_present |=> resample_period == $past(meas_period); endproperty
    a_zx: assert property (p_zx) else $error("measured period unused");
    property p_nom; !zx_present |=> resample_period == (line_freq_60 ? POC_PERIOD_60HZ : POC_PERIOD_50HZ); endproperty
    a_nom: assert property (p_nom) else $error("nominal period wrong");
    c_wc: cover property (wc ##1 reg_rd);
    c_ev: cover property (|pulse_flag_set);
    c_zx: cover property (zx_present);
endmodule
bind poc_top poc_top_assertions u_chk (.*);
`default_nettype wire

/* verif/tb_pulse_output_phase_config.sv */
`default_nettype none
module tb_pulse_output_phase_config
    import poc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, zx_present = 0;
    logic [11:0] reg_addr = 0, phase_include;
    logic [15:0] reg_wdata = 0, reg_rdata, energy_type_oh;
    logic [3:0] pulse_raw = 0, pulse_event = 0, pulse_flag_set, accum_mode;
    logic pulse_out_one, pulse_out_two, pulse_out_three, pulse_out_four, line_freq_60;
    logic [19:0] meas_period = 20'h12345, resample_period;
    logic signed [23:0] phase_a_current = 24'sd1000, phase_b_current = 24'sd77, phase_c_current = -24'sd300;
    logic signed [23:0] phase_a_voltage = 24'sd5000, phase_b_voltage = 24'sd61, phase_c_voltage = -24'sd900;
    logic signed [24:0] ib_used, va_used, vb_used, vc_used, a, b, c, eb;
    int fails = 0, tests_run = 0;
    poc_top uut (.*);
    initial forever #12.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    task automatic chk(logic [24:0] got, logic [24:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(logic [11:0] ad, logic [15:0] d);
        @(negedge clk);
        reg_addr = ad;
        reg_wdata = d;
        reg_wr = 1;
        @(negedge clk);
        reg_wr = 0;
        @(negedge clk);
    endtask
    task automatic rd(logic [11:0] ad, logic [15:0] e);
        @(negedge clk);
        reg_addr = ad;
        reg_rd = 1;
        @(negedge clk);
        reg_rd = 0;
        chk(reg_rdata, e);
    endtask
    function automatic logic [3:0] ty(logic [2:0] k);
        return k == 3'h1 ? POC_OH_REACTIVE : k == 3'h2 ? POC_OH_APPARENT : k == 3'h4 ? POC_OH_FUND_REACT : POC_OH_ACTIVE;
    endfunction
    ////////////////////////////////////////////////////////////////
    task automatic t_types;
        logic [2:0] k;
        for (int i = 0; i < 8; i++) begin
            k = 3'(i);
            wr(POC_ADDR_PULSE_CFG, {4'h0, k + 3'h3, k + 3'h2, k + 3'h1, k});
            chk(energy_type_oh, {ty(k + 3'h3), ty(k + 3'h2), ty(k + 3'h1), ty(k)});
        end
    endtask
    task automatic t_regs;
        chk(energy_type_oh, 16'h1111);
        rd(POC_ADDR_COMP, 16'h0000);
        rd(POC_ADDR_ACC, 16'h0000);
        wr(POC_ADDR_COMP, 16'hFA5C);
        rd(POC_ADDR_COMP, 16'h0A5C);
        chk(phase_include, 12'hA5C);
        wr(12'h4FF, 16'hFFFF);
        rd(12'h4FF, 16'h0000);
        wr(POC_ADDR_ACC, 16'hFFFF);
        rd(POC_ADDR_ACC, 16'h01FF);
        chk(line_freq_60, 1'b1);
        chk(accum_mode, 4'hF);
        chk(resample_period, POC_PERIOD_60HZ);
        zx_present = 1;
        @(negedge clk);
        chk(resample_period, meas_period);
        zx_present = 0;
        wr(POC_ADDR_ACC, 16'h0000);
        chk(resample_period, POC_PERIOD_50HZ);
        chk(accum_mode, 4'h0);
        chk(ib_used, 25'(phase_b_current));
    endtask
    task automatic t_derive;
        a = 25'(phase_a_voltage);
        b = 25'(phase_b_voltage);
        c = 25'(phase_c_voltage);
        for (int w = 0; w < 8; w++) begin
            wr(POC_ADDR_ACC, 16'h0080 | 16'(w << 4));
            eb = w == 1 || w == 4 ? a - c : w == 2 ? -a - c : w == 3 ? -a : b;
            chk(vb_used, eb);
            chk(va_used, w == 4 ? a - b : a);
            chk(vc_used, w == 4 ? c - b : c);
            chk(ib_used, -25'(phase_a_current) - 25'(phase_c_current));
        end
    endtask
    task automatic t_pulse;
        wr(POC_ADDR_PULSE_CFG, 16'hA000);
        pulse_event = 4'hF;
        @(negedge clk);
        pulse_event = 4'h0;
        pulse_raw = 4'h4;
        chk({pulse_out_four, pulse_out_three, pulse_out_two, pulse_out_one}, 4'hA);
        chk(pulse_flag_set, 4'h5);
        @(negedge clk);
        pulse_raw = 4'h0;
        chk({pulse_out_four, pulse_out_three, pulse_out_two, pulse_out_one}, 4'hE);
        chk(pulse_flag_set, 4'h0);
    endtask
    task automatic results;
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge clk);
        nrst = 1;
        t_regs;
        t_types;
        t_derive;
        t_pulse;
        results;
    end
    initial begin
        #50000;
        fails++;
        results;
    end
endmodule
`default_nettype wire
